// *** src/flash_cmd_pkg.sv ***
// package: register map, fields, reset values and limits of the flash command block
package flash_cmd_pkg;
  localparam logic [4:0]  OFS_INDEX        = 5'h02;
  localparam logic [4:0]  OFS_CONFIG       = 5'h04;
  localparam logic [4:0]  OFS_STATUS       = 5'h06;
  localparam logic [4:0]  OFS_ERR_STATUS   = 5'h07;
  localparam logic [4:0]  OFS_WORD_HI      = 5'h0A;
  localparam logic [4:0]  OFS_WORD_LO      = 5'h0B;
  localparam logic [4:0]  OFS_FAULT_IN     = 5'h10;
  localparam int          CFG_IRQ_EN_BIT   = 7;
  localparam int          CFG_IGN_SF_BIT   = 4;
  localparam int          CFG_FORCE_DOUBLE_FAULT_BIT     = 1;
  localparam int          CFG_FORCE_SINGLE_FAULT_BIT     = 0;
  localparam logic [7:0]  CFG_MASK         = 8'h93;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam int          ST_CCF_BIT       = 7;
  localparam int          ST_ACC_BIT       = 5;
  localparam int          ST_PV_BIT        = 4;
  localparam int          ST_RES_HI_BIT    = 1;
  localparam int          ST_RES_LO_BIT    = 0;
  localparam int          ERR_SF_BIT       = 0;
  localparam int          ERR_DF_BIT       = 1;
  localparam logic [7:0]  CMD_PARTITION    = 8'h20;
  localparam logic [7:0]  CMD_EEE_QUERY    = 8'h15;
  localparam logic [7:0]  CMD_LOAD_FIELD   = 8'h10;
  localparam logic [15:0] DF_SECTORS       = 16'h0080;
  localparam logic [15:0] BUF_SECTORS_MAX  = 16'h0010;
  localparam logic [15:0] EEE_MIN_SECTORS  = 16'h000C;
  localparam logic [15:0] EEE_MIN_RATIO    = 16'h0008;
  localparam int          SECTOR_BYTES     = 256;
  localparam int          ROW_BYTES        = 64;
  localparam int          ROWS_PER_SECTOR  = SECTOR_BYTES / ROW_BYTES;
  localparam logic [23:0] NVR_USER_ADDR    = 24'h12_0000;
  localparam logic [23:0] NVR_USER_DUP     = 24'h12_0002;
  localparam logic [23:0] NVR_BUF_ADDR     = 24'h12_0004;
  localparam logic [23:0] NVR_BUF_DUP      = 24'h12_0006;
  localparam int          VERIFY_TIME_NS   = 1000;
  localparam int          CLK_PERIOD_NS    = 20;
  localparam logic [7:0]  VERIFY_CYCLES    = 8'((VERIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_CHECK  = 6'b000010,
    S_VERIFY = 6'b000100,
    S_PROG   = 6'b001000,
    S_QUERY  = 6'b010000,
    S_DONE   = 6'b100000
  } seq_state_t;
endpackage

// *** src/flash_cmd_config_partition.sv ***
// flash command sequencer: configuration, query checks and data flash partition
//
// Function
// - config bit 7 set: interrupt requested while command complete flag is set.
// - config bit 4 set suppresses single-bit fault reports and their interrupt.
// - only irq enable, ignore, two force bits writable; others read zero.
// - query command: access error when word index nonzero at launch.
// - query command: access error when load-field sequence still active.
// - query command: access error if mode disallows; other flags untouched.
// - user partition count accepted only when at most 128.
// - buffer partition count accepted only when at most 16.
// - nonzero buffer count needs at least 12 sectors outside user partition.
// - nonzero buffer count needs remaining sectors over buffer count at least 8.
// - after validation, erase-verify data flash and information row first.
// - program user count into information row at 0x12_0000.
// - data flash is 128 sectors of 256 bytes, four 64-byte rows each.
// - buffer count stored at 0x12_0004; duplicates written too.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module flash_cmd_config_partition
  import flash_cmd_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        cmd_mode_ok_in,
  input  wire logic        array_single_fault_in,
  input  wire logic        array_double_fault_in,
  input  wire logic        verify_blank_in,
  output logic      [7:0]  rdata_out,
  output logic             cmd_irq_out,
  output logic             single_fault_irq_out,
  output logic             nvr_wr_out,
  output logic      [23:0] nvr_addr_out,
  output logic      [15:0] nvr_data_out,
  output logic             force_double_fault_out,
  output logic             force_single_fault_out
);

  typedef struct packed {
    logic [7:0]  config_reg;
    logic [2:0]  command_word_index;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [15:0] word2;
    logic        command_complete_flag;
    logic        access_error_flag;
    logic        protection_violation_flag;
    logic        command_result_hi;
    logic        command_result_lo;
    logic        single_fault_flag;
    logic        double_fault_flag;
    logic        load_field_active;
    seq_state_t  state;
    logic [7:0]  timer;
    logic [1:0]  prog_step;
    logic [7:0]  rdata;
    logic        cmd_irq;
    logic        sf_irq;
    logic        nvr_wr;
    logic [23:0] nvr_addr;
    logic [15:0] nvr_data;
    logic [2:0]  sf_sync;
    logic [2:0]  df_sync;
    logic [2:0]  vb_sync;
    logic        sf_seen;
    logic        df_seen;
  } state_t;

  logic [1:0] rst_sync_ff;
  logic       rstn;
  state_t     cur_ff;
  state_t     nxt_cur;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rstn = rst_sync_ff[1];

  // validation of partition sizes
  function automatic logic part_ok(input logic [15:0] user_cnt, input logic [15:0] buf_cnt);
    logic [15:0] rest;
    rest = DF_SECTORS - user_cnt;
    part_ok = 1'b1;
    if (user_cnt > DF_SECTORS) begin
      part_ok = 1'b0;
    end
    if (buf_cnt > BUF_SECTORS_MAX) begin
      part_ok = 1'b0;
    end
    if (buf_cnt != 16'h0000 && user_cnt <= DF_SECTORS) begin
      if (rest < EEE_MIN_SECTORS) begin
        part_ok = 1'b0;
      end
      if (rest / buf_cnt < EEE_MIN_RATIO) begin
        part_ok = 1'b0;
      end
    end
  endfunction

  // command word selected by the current index
  function automatic logic [15:0] word_at(input logic [2:0]  idx,
                                          input logic [15:0] w0,
                                          input logic [15:0] w1,
                                          input logic [15:0] w2);
    case (idx)
      3'h1: begin
        word_at = w1;
      end
      3'h2: begin
        word_at = w2;
      end
      default: begin
        word_at = w0;
      end
    endcase
  endfunction

  // stable synchronised level: second and third stage agree
  function automatic logic sync_level(input logic [2:0] s, input logic prev);
    sync_level = (s[2] == s[1]) ? s[1] : prev;
  endfunction

  always_comb begin
    logic [7:0]  stat;
    logic        sf_now;
    logic        df_now;
    logic        vb_now;
    logic [15:0] cur_word;
    stat   = 8'h00;
    cur_word = word_at(cur_ff.command_word_index, cur_ff.word0, cur_ff.word1, cur_ff.word2);
    sf_now = 1'b0;
    df_now = 1'b0;
    vb_now = 1'b0;
    nxt_cur = cur_ff;
    nxt_cur.sf_sync = {cur_ff.sf_sync[1:0], array_single_fault_in};
    nxt_cur.df_sync = {cur_ff.df_sync[1:0], array_double_fault_in};
    nxt_cur.vb_sync = {cur_ff.vb_sync[1:0], verify_blank_in};
    sf_now = sync_level(cur_ff.sf_sync, cur_ff.sf_seen);
    df_now = sync_level(cur_ff.df_sync, cur_ff.df_seen);
    vb_now = (cur_ff.vb_sync[2] == cur_ff.vb_sync[1]) & cur_ff.vb_sync[1];
    nxt_cur.sf_seen = sf_now;
    nxt_cur.df_seen = df_now;
    nxt_cur.nvr_wr = 1'b0;

    stat[ST_CCF_BIT]    = cur_ff.command_complete_flag;
    stat[ST_ACC_BIT]    = cur_ff.access_error_flag;
    stat[ST_PV_BIT]     = cur_ff.protection_violation_flag;
    stat[ST_RES_HI_BIT] = cur_ff.command_result_hi;
    stat[ST_RES_LO_BIT] = cur_ff.command_result_lo;

    nxt_cur.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        OFS_INDEX:      nxt_cur.rdata = {5'h00, cur_ff.command_word_index};
        OFS_CONFIG:     nxt_cur.rdata = cur_ff.config_reg & CFG_MASK;
        OFS_STATUS:     nxt_cur.rdata = stat;
        OFS_ERR_STATUS: nxt_cur.rdata = {6'h00, cur_ff.double_fault_flag,
                                         cur_ff.single_fault_flag};
        OFS_WORD_HI:    nxt_cur.rdata = cur_word[15:8];
        OFS_WORD_LO:    nxt_cur.rdata = cur_word[7:0];
        default:        nxt_cur.rdata = 8'h00;
      endcase
    end

    if (wr_in && cur_ff.command_complete_flag) begin
      case (addr_in)
        OFS_INDEX:  nxt_cur.command_word_index = wdata_in[2:0];
        OFS_CONFIG: nxt_cur.config_reg = wdata_in & CFG_MASK;
        OFS_WORD_HI, OFS_WORD_LO: begin
          case (cur_ff.command_word_index)
            3'h0: begin
              if (addr_in == OFS_WORD_HI) begin
                nxt_cur.word0[15:8] = wdata_in;
              end else begin
                nxt_cur.word0[7:0] = wdata_in;
              end
            end
            3'h1: begin
              if (addr_in == OFS_WORD_HI) begin
                nxt_cur.word1[15:8] = wdata_in;
              end else begin
                nxt_cur.word1[7:0] = wdata_in;
              end
            end
            3'h2: begin
              if (addr_in == OFS_WORD_HI) begin
                nxt_cur.word2[15:8] = wdata_in;
              end else begin
                nxt_cur.word2[7:0] = wdata_in;
              end
            end
            default: nxt_cur.word0 = cur_ff.word0;
          endcase
        end
        OFS_STATUS: begin
          if (wdata_in[ST_ACC_BIT]) begin
            nxt_cur.access_error_flag = 1'b0;
          end
          if (wdata_in[ST_PV_BIT]) begin
            nxt_cur.protection_violation_flag = 1'b0;
          end
          if (wdata_in[ST_CCF_BIT]) begin
            nxt_cur.command_complete_flag = 1'b0;
            nxt_cur.command_result_hi = 1'b0;
            nxt_cur.command_result_lo = 1'b0;
            nxt_cur.state = S_CHECK;
          end
        end
        OFS_ERR_STATUS: begin
          if (wdata_in[ERR_SF_BIT]) begin
            nxt_cur.single_fault_flag = 1'b0;
          end
          if (wdata_in[ERR_DF_BIT]) begin
            nxt_cur.double_fault_flag = 1'b0;
          end
        end
        default: nxt_cur.config_reg = cur_ff.config_reg;
      endcase
    end

    // fault events: set wins over clear
    if (sf_now && !cur_ff.sf_seen && !cur_ff.config_reg[CFG_IGN_SF_BIT]) begin
      nxt_cur.single_fault_flag = 1'b1;
    end
    if (df_now && !cur_ff.df_seen) begin
      nxt_cur.double_fault_flag = 1'b1;
    end

    case (cur_ff.state)
      S_IDLE: nxt_cur.timer = 8'h00;
      S_CHECK: begin
        nxt_cur.timer = VERIFY_CYCLES;
        nxt_cur.prog_step = 2'h0;
        if (cur_ff.word0[15:8] == CMD_EEE_QUERY) begin
          if (cur_ff.command_word_index != 3'h0 || cur_ff.load_field_active
              || !cmd_mode_ok_in) begin
            nxt_cur.access_error_flag = 1'b1;
            nxt_cur.state = S_DONE;
          end else begin
            nxt_cur.state = S_QUERY;
          end
        end else if (cur_ff.word0[15:8] == CMD_PARTITION) begin
          if (part_ok(cur_ff.word1, cur_ff.word2) && cur_ff.command_word_index == 3'h2)
            nxt_cur.state = S_VERIFY;
          else begin
            nxt_cur.access_error_flag = 1'b1;
            nxt_cur.state = S_DONE;
          end
        end else if (cur_ff.word0[15:8] == CMD_LOAD_FIELD) begin
          nxt_cur.load_field_active = 1'b1;
          nxt_cur.state = S_DONE;
        end else begin
          nxt_cur.access_error_flag = 1'b1;
          nxt_cur.state = S_DONE;
        end
      end
      S_VERIFY: begin
        if (cur_ff.timer != 8'h00) begin
          nxt_cur.timer = cur_ff.timer - 8'h01;
        end else if (vb_now) begin
          nxt_cur.state = S_PROG;
        end else begin
          nxt_cur.command_result_lo = 1'b1;
          nxt_cur.state = S_DONE;
        end
      end
      S_PROG: begin
        nxt_cur.nvr_wr = 1'b1;
        nxt_cur.prog_step = cur_ff.prog_step + 2'h1;
        case (cur_ff.prog_step)
          2'h0: begin
            nxt_cur.nvr_addr = NVR_USER_ADDR;
            nxt_cur.nvr_data = cur_ff.word1;
          end
          2'h1: begin
            nxt_cur.nvr_addr = NVR_USER_DUP;
            nxt_cur.nvr_data = cur_ff.word1;
          end
          2'h2: begin
            nxt_cur.nvr_addr = NVR_BUF_ADDR;
            nxt_cur.nvr_data = cur_ff.word2;
          end
          default: begin
            nxt_cur.nvr_addr = NVR_BUF_DUP;
            nxt_cur.nvr_data = cur_ff.word2;
            nxt_cur.state = S_DONE;
          end
        endcase
      end
      S_QUERY: nxt_cur.state = S_DONE;
      S_DONE: begin
        nxt_cur.command_complete_flag = 1'b1;
        nxt_cur.state = S_IDLE;
      end
      default: nxt_cur.state = S_IDLE;
    endcase

    nxt_cur.cmd_irq = nxt_cur.command_complete_flag & nxt_cur.config_reg[CFG_IRQ_EN_BIT];
    nxt_cur.sf_irq = nxt_cur.single_fault_flag & ~nxt_cur.config_reg[CFG_IGN_SF_BIT];
  end

  always_ff @(posedge clk_sys_in or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '{config_reg: CFG_RESET, command_complete_flag: 1'b1, state: S_IDLE,
                  default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign rdata_out              = cur_ff.rdata;
  assign cmd_irq_out            = cur_ff.cmd_irq;
  assign single_fault_irq_out   = cur_ff.sf_irq;
  assign nvr_wr_out             = cur_ff.nvr_wr;
  assign nvr_addr_out           = cur_ff.nvr_addr;
  assign nvr_data_out           = cur_ff.nvr_data;
  assign force_double_fault_out = cur_ff.config_reg[CFG_FORCE_DOUBLE_FAULT_BIT];
  assign force_single_fault_out = cur_ff.config_reg[CFG_FORCE_SINGLE_FAULT_BIT];

endmodule // flash_cmd_config_partition

// *** testbench/flash_cmd_config_partition_monitor.sv ***
// checker: port relations of the flash command block
`timescale 1ns/1ps
module flash_cmd_config_partition_monitor
  import flash_cmd_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic [4:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        cmd_mode_ok_in,
  input wire logic        array_single_fault_in,
  input wire logic        array_double_fault_in,
  input wire logic        verify_blank_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        cmd_irq_out,
  input wire logic        single_fault_irq_out,
  input wire logic        nvr_wr_out,
  input wire logic [23:0] nvr_addr_out,
  input wire logic [15:0] nvr_data_out,
  input wire logic        force_double_fault_out,
  input wire logic        force_single_fault_out
);
  default clocking dcb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  AST_FORCE_WR: assert property ($changed(force_single_fault_out) |->
    ($past(wr_in) && $past(addr_in) == OFS_CONFIG) ||
    ($past(wr_in, 2) && $past(addr_in, 2) == OFS_CONFIG))
    else $error("force bit changed without config write");
  AST_NVR_SEQ: assert property (nvr_wr_out && nvr_addr_out == NVR_USER_ADDR |=>
    nvr_wr_out && nvr_addr_out == NVR_USER_DUP ##1 nvr_wr_out && nvr_addr_out == NVR_BUF_ADDR
    ##1 nvr_wr_out && nvr_addr_out == NVR_BUF_DUP ##1 !nvr_wr_out)
    else $error("info row write order wrong");
  AST_NVR_FIRST: assert property ($rose(nvr_wr_out) |-> nvr_addr_out == NVR_USER_ADDR)
    else $error("info row writes not started at user count");
  AST_NVR_DUP: assert property (nvr_wr_out && nvr_addr_out[1] |->
    $past(nvr_wr_out) && nvr_data_out == $past(nvr_data_out))
    else $error("duplicate differs from primary");
  AST_USER_MAX: assert property (nvr_wr_out && nvr_addr_out == NVR_USER_ADDR |->
    nvr_data_out <= DF_SECTORS)
    else $error("user count above limit programmed");
  AST_BUF_MAX: assert property (nvr_wr_out && nvr_addr_out == NVR_BUF_ADDR |->
    nvr_data_out <= BUF_SECTORS_MAX)
    else $error("buffer count above limit programmed");
  AST_BUF_RATIO: assert property (nvr_wr_out && nvr_addr_out == NVR_BUF_ADDR &&
    nvr_data_out != 16'h0000 |-> (DF_SECTORS - $past(nvr_data_out, 2)) >= EEE_MIN_SECTORS &&
    (DF_SECTORS - $past(nvr_data_out, 2)) / nvr_data_out >= EEE_MIN_RATIO)
    else $error("buffer partition rules broken");
  AST_BUSY_IRQ: assert property (nvr_wr_out |-> !cmd_irq_out)
    else $error("complete interrupt while programming");
endmodule // flash_cmd_config_partition_monitor
bind flash_cmd_config_partition flash_cmd_config_partition_monitor mon (.clk_sys_in, .rstn_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .cmd_mode_ok_in, .array_single_fault_in,
  .array_double_fault_in, .verify_blank_in, .rdata_out, .cmd_irq_out, .single_fault_irq_out,
  .nvr_wr_out, .nvr_addr_out, .nvr_data_out, .force_double_fault_out, .force_single_fault_out);

// *** testbench/flash_cmd_config_partition_tb.sv ***
// testbench: config, fault, partition and query scenarios
`timescale 1ns/1ps
module flash_cmd_config_partition_tb
  import flash_cmd_pkg::*;
;
  logic        clk_sys_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, cmd_mode_ok_in = 1;
  logic        array_single_fault_in = 0, array_double_fault_in = 0, verify_blank_in = 1;
  logic [4:0]  addr_in = '0;
  logic [7:0]  wdata_in = '0, rdata_out;
  logic        cmd_irq_out, single_fault_irq_out, nvr_wr_out;
  logic        force_double_fault_out, force_single_fault_out;
  logic [23:0] nvr_addr_out, q_addr[$];
  logic [15:0] nvr_data_out, q_data[$];
  int          fail_count = 0, cmp_count = 0, cycles = 0;
  flash_cmd_config_partition dut (.clk_sys_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .cmd_mode_ok_in, .array_single_fault_in, .array_double_fault_in, .verify_blank_in,
    .rdata_out, .cmd_irq_out, .single_fault_irq_out, .nvr_wr_out, .nvr_addr_out,
    .nvr_data_out, .force_double_fault_out, .force_single_fault_out);
  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (nvr_wr_out === 1'b1) begin
      q_addr.push_back(nvr_addr_out);
      q_data.push_back(nvr_data_out);
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic run(input logic [7:0] exp, input logic [7:0] m);
    logic [7:0] s;
    wr(OFS_STATUS, 8'h80);
    s = 8'h00;
    for (int n = 0; n < 300 && s[ST_CCF_BIT] !== 1'b1; n++) rd(OFS_STATUS, s);
    chk(s & m, exp);
    wr(OFS_STATUS, 8'h33);
  endtask
  task automatic t_cfg();
    logic [7:0] d;
    rd(OFS_CONFIG, d);
    chk(d, 8'h00);
    wr(OFS_CONFIG, 8'hFF);
    rd(OFS_CONFIG, d);
    chk(d, 8'h93);
    chk({force_double_fault_out, force_single_fault_out, cmd_irq_out}, 3'b111);
    wr(OFS_CONFIG, 8'h00);
    rd(5'h1F, d);
    chk({d, force_double_fault_out, force_single_fault_out, cmd_irq_out}, 11'h0);
  endtask
  task automatic t_sf(input logic [7:0] cfg, input logic exp);
    logic [7:0] d;
    wr(OFS_CONFIG, cfg);
    array_single_fault_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    array_single_fault_in <= 1'b0;
    rd(OFS_ERR_STATUS, d);
    chk({single_fault_irq_out, d[ERR_SF_BIT]}, {exp, exp});
    wr(OFS_ERR_STATUS, 8'h01);
  endtask
  task automatic part(input logic [7:0] u, b, input logic bl, input logic [7:0] exp);
    verify_blank_in <= bl;
    q_addr.delete();
    q_data.delete();
    wr(OFS_CONFIG, 8'h80);
    wr(OFS_INDEX, 8'h00);
    wr(OFS_WORD_HI, CMD_PARTITION);
    wr(OFS_INDEX, 8'h01);
    wr(OFS_WORD_LO, u);
    wr(OFS_INDEX, 8'h02);
    wr(OFS_WORD_LO, b);
    run(exp, 8'hFF);
    chk(cmd_irq_out, 1'b1);
    chk(24'(q_addr.size()), exp == 8'h80 ? 24'h4 : 24'h0);
    if (exp == 8'h80) begin
      chk({q_addr[0], q_data[0]}, {NVR_USER_ADDR, 8'h00, u});
      chk({q_addr[2], q_data[2]}, {NVR_BUF_ADDR, 8'h00, b});
    end
  endtask
  task automatic query(input logic [7:0] c, idx, input logic ok, input logic [7:0] exp, m);
    cmd_mode_ok_in <= ok;
    wr(OFS_INDEX, 8'h00);
    wr(OFS_WORD_HI, c);
    wr(OFS_INDEX, idx);
    run(exp, m);
  endtask
  initial begin
    wait (cycles == 30000);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_cfg();
    t_sf(8'h00, 1'b1);
    t_sf(8'h10, 1'b0);
    part(8'h40, 8'h04, 1'b1, 8'h80);
    part(8'h80, 8'h00, 1'b1, 8'h80);
    part(8'h81, 8'h00, 1'b1, 8'hA0);
    part(8'h00, 8'h10, 1'b1, 8'h80);
    part(8'h00, 8'h11, 1'b1, 8'hA0);
    part(8'h74, 8'h01, 1'b1, 8'h80);
    part(8'h75, 8'h01, 1'b1, 8'hA0);
    part(8'h40, 8'h08, 1'b1, 8'h80);
    part(8'h60, 8'h05, 1'b1, 8'hA0);
    part(8'h40, 8'h04, 1'b0, 8'h81);
    query(CMD_EEE_QUERY, 8'h00, 1'b1, 8'h80, 8'hFF);
    query(CMD_EEE_QUERY, 8'h01, 1'b1, 8'hA0, 8'hFF);
    query(CMD_EEE_QUERY, 8'h00, 1'b0, 8'hA0, 8'hFF);
    query(CMD_LOAD_FIELD, 8'h00, 1'b1, 8'h80, 8'h80);
    query(CMD_EEE_QUERY, 8'h00, 1'b1, 8'hA0, 8'hFF);
    stop_test();
  end
endmodule // flash_cmd_config_partition_tb
